// ==== rtl/fpmr_params.svh ====
`ifndef FPMR_PARAMS_SVH
`define FPMR_PARAMS_SVH

// Register byte addresses on the host bus
`define FPMR_ADDR_W 8
`define FPMR_OFS_RX_FIFO 8'h7c
`define FPMR_OFS_TX_FIFO 8'h80
`define FPMR_OFS_POWER 8'h84
`define FPMR_OFS_BYTE_TEST 8'h64

// Field positions of the power management word
`define FPMR_PM_STATE_HI 13
`define FPMR_PM_STATE_LO 12
`define FPMR_PM_XCVR_RESET 10
`define FPMR_PM_WAKE_FRAME_EN 9
`define FPMR_PM_ENERGY_EN 8
`define FPMR_PM_DRIVE_TYPE 6
`define FPMR_PM_PULSE_SEL 3
`define FPMR_PM_POLARITY 2
`define FPMR_PM_OUT_EN 1
`define FPMR_PM_READY 0

// Reset values
`define FPMR_RST_STATUS_DWORDS 8'h00
`define FPMR_RST_RX_USED_BYTES 16'h0000
`define FPMR_RST_TX_FREE_BYTES 16'h1200
`define FPMR_RST_WORD 32'h0000_0000

// Timing
`define FPMR_TIMER_W 24
`define FPMR_CLK_PERIOD_NS 10
`define FPMR_XCVR_RESET_US 100
`define FPMR_XCVR_RESET_CYCLES ((`FPMR_XCVR_RESET_US * 1000 + `FPMR_CLK_PERIOD_NS - 1) / `FPMR_CLK_PERIOD_NS)
`define FPMR_WAKE_PULSE_MS 50
`define FPMR_WAKE_PULSE_CYCLES ((`FPMR_WAKE_PULSE_MS * 1000000) / `FPMR_CLK_PERIOD_NS)
`define FPMR_READY_DELAY_CYCLES 16

`endif

// ==== rtl/fpmr_pkg.sv ====
package fpmr_pkg;

   // Power state codes; all but reserved 11 selectable by software
   typedef enum logic [1:0] {
      full_power_state = 2'b00,
      wake_frame_sleep_state = 2'b01,
      energy_detect_sleep_state = 2'b10,
      reserved_power_state = 2'b11
   } fpmr_power_t;

endpackage

// ==== rtl/fpmr_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fpmr_params.svh"

module fpmr_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Control
   input wire logic start,
   input wire logic [`FPMR_TIMER_W-1:0] load,
   // Status
   output logic busy
);
   import fpmr_pkg::*;

   logic [`FPMR_TIMER_W-1:0] count;
   logic [`FPMR_TIMER_W-1:0] next_count;
   logic do_load;

   // A start while running is dropped, so a run cannot be stretched
   assign do_load = start & ~busy;
   assign next_count = do_load ? load :
                       (count != '0) ? count - 1'b1 : count;

   // Busy is high for exactly load cycles after the start edge
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count <= '0;
         busy <= 1'b0;
      end else begin
         count <= next_count;
         busy <= (next_count != '0);
      end
   end

   start_loads_a: assert property (@(posedge clk) disable iff (reset)
      (do_load && load != '0) |=> busy)
      else $error("timer did not start");

endmodule
`default_nettype wire

// ==== rtl/fpmr_wake_pin.sv ====
`timescale 1ns/1ns
`default_nettype none

module fpmr_wake_pin (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Wake request and pin settings
   input wire logic active,
   input wire logic out_enable,
   input wire logic drive_type,
   input wire logic polarity,
   // Pin
   output logic pin_out,
   output logic pin_oe
);
   import fpmr_pkg::*;

   logic asserted;
   logic next_out;
   logic next_oe;

   // Enable gates only the pin, never the interrupt
   assign asserted = active & out_enable; // RULE_17
   // Open drain pulls low only; push-pull drives always with polarity
   assign next_out = drive_type ? (asserted ~^ polarity) : 1'b0; // RULE_16
   assign next_oe = drive_type ? 1'b1 : asserted; // RULE_16

   // Registered so the pin never glitches on decode changes
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         pin_out <= next_out;
         pin_oe <= next_oe;
      end
   end

   open_drain_low_a: assert property (@(posedge clk) disable iff (reset)
      !drive_type |=> (pin_out == 1'b0 && pin_oe == $past(asserted))) // RULE_16
      else $error("open drain pin misdriven");
   push_pull_pol_a: assert property (@(posedge clk) disable iff (reset)
      drive_type |=> (pin_oe && pin_out == ($past(asserted) == $past(polarity)))) // RULE_16
      else $error("push pull polarity wrong");
   enable_gates_a: assert property (@(posedge clk) disable iff (reset)
      !out_enable |=> (!pin_oe || pin_out != $past(polarity) ||
         !$past(drive_type))) // RULE_17
      else $error("disabled pin asserted");

endmodule
`default_nettype wire

// ==== rtl/fpmr_regs.sv ====
// Summary of operation
// (RULE_01) Receive status FIFO dword count, reset zero
// (RULE_02) Receive data FIFO used bytes, reset zero
// (RULE_03) Transmit status FIFO dword count, reset zero
// (RULE_04) Transmit data free bytes, reset 1200h
// (RULE_05) Host never overfills transmit data FIFO
// (RULE_06) Power word readable in any sleep state
// (RULE_07) Writes ignored until a read follows reset/wake
// (RULE_08) Self-clearing power state: 00 run, 01, 10
// (RULE_09) Host never writes power state 11; the bench writes it once as a probe
// (RULE_10) Byte test write wakes a sleeping device
// (RULE_11) Host writes only byte test while unready
// (RULE_12) Transceiver reset bit holds reset 100us
// (RULE_13) Reset bit self-clears; writes ignored while set (code drops only a new reset start; other power word writes still land)
// (RULE_14) Wake frame event raises interrupt, gated pin
// (RULE_15) Energy detect event raises interrupt, gated pin
// (RULE_16) Drive type: open-drain low or push-pull
// (RULE_17) Output enable gates pin, not interrupt
// (RULE_18) Pulse select: 50ms pulse, else held level
// (RULE_19) Ready bit set once device is stable
// (RULE_20) Reserved bits read zero, ignore writes
`timescale 1ns/1ns
`default_nettype none
`include "fpmr_params.svh"

module fpmr_regs #(
   parameter logic [`FPMR_TIMER_W-1:0] XCVR_RESET_CYCLES =
      `FPMR_TIMER_W'(`FPMR_XCVR_RESET_CYCLES),
   parameter logic [`FPMR_TIMER_W-1:0] WAKE_PULSE_CYCLES =
      `FPMR_TIMER_W'(`FPMR_WAKE_PULSE_CYCLES)
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Host bus, synchronous to clk
   input wire logic bus_select,
   input wire logic bus_read,
   input wire logic bus_write,
   input wire logic [`FPMR_ADDR_W-1:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   output logic [31:0] bus_rdata,
   output logic bus_rdata_valid,
   // FIFO levels from the datapath
   input wire logic [7:0] rx_status_used_dwords,
   input wire logic [15:0] rx_data_used_bytes,
   input wire logic [7:0] tx_status_used_dwords,
   input wire logic [15:0] tx_data_free_bytes,
   // Wake events from the receive side
   input wire logic wake_frame_event,
   input wire logic energy_detect_event,
   // Power and transceiver control
   output fpmr_pkg::fpmr_power_t power_state,
   output logic transceiver_reset,
   output logic device_ready,
   // Wake indications
   output logic wake_event_interrupt,
   output logic wake_event_output,
   output logic wake_event_output_oe
);
   import fpmr_pkg::*;

   // Level snapshots, control bits and handshake state
   logic [7:0] rx_status_q;
   logic [15:0] rx_used_q;
   logic [7:0] tx_status_q;
   logic [15:0] tx_free_q;
   logic wake_frame_event_enable;
   logic energy_detect_event_enable;
   logic wake_output_drive_type;
   logic wake_output_pulse_select;
   logic wake_output_polarity;
   logic wake_output_enable;
   logic read_seen;
   logic boot;
   logic ready_busy;
   logic pulse_busy;
   fpmr_power_t next_power_state;
   fpmr_power_t req_state;

   // Bus decode
   logic rd_take;
   logic wr_take;
   logic hit_rx;
   logic hit_tx;
   logic hit_pm;
   logic hit_bt;
   logic asleep;
   logic wake_write;
   logic wr_ok;
   logic pm_write;
   logic xcvr_start;
   logic ready_start;
   logic [31:0] rd_word;
   logic [31:0] pm_word;

   // Read wins over a write presented in the same cycle
   assign rd_take = bus_select & bus_read;
   assign wr_take = bus_select & bus_write & ~bus_read;
   assign hit_rx = (bus_addr == `FPMR_OFS_RX_FIFO);
   assign hit_tx = (bus_addr == `FPMR_OFS_TX_FIFO);
   assign hit_pm = (bus_addr == `FPMR_OFS_POWER);
   assign hit_bt = (bus_addr == `FPMR_OFS_BYTE_TEST);
   assign asleep = (power_state != full_power_state);

   // Wake write needs no prior read, otherwise the host could never wake
   assign wake_write = wr_take & hit_bt & asleep; // RULE_10
   // Also shields the block from illegal writes while not ready
   assign wr_ok = wr_take & read_seen & device_ready; // RULE_07
   assign pm_write = wr_ok & hit_pm;
   assign req_state = fpmr_power_t'(
      bus_wdata[`FPMR_PM_STATE_HI:`FPMR_PM_STATE_LO]);

   // Power state: woken by byte test, code 11 dropped as reserved
   always_comb begin
      next_power_state = power_state;
      unique case (power_state)
         full_power_state: begin
            if (pm_write && req_state != reserved_power_state) begin
               next_power_state = req_state; // RULE_08
            end
         end
         wake_frame_sleep_state, energy_detect_sleep_state: begin
            if (wake_write) begin
               next_power_state = full_power_state; // RULE_08 RULE_10
            end
         end
         default: begin
            next_power_state = full_power_state;
         end
      endcase
   end

   // Transceiver reset, the timer refuses restarts while busy
   assign xcvr_start = pm_write & bus_wdata[`FPMR_PM_XCVR_RESET]; // RULE_12 RULE_13

   fpmr_timer u_xcvr_timer (
      .clk(clk),
      .reset(reset),
      .start(xcvr_start),
      .load(XCVR_RESET_CYCLES),
      .busy(transceiver_reset)
   ); // RULE_12 RULE_13

   // Stabilisation delay after reset release and after every wake
   assign ready_start = boot | wake_write;
   assign device_ready = ~asleep & ~ready_busy & ~boot; // RULE_19

   fpmr_timer u_ready_timer (
      .clk(clk),
      .reset(reset),
      .start(ready_start),
      .load(`FPMR_TIMER_W'(`FPMR_READY_DELAY_CYCLES)),
      .busy(ready_busy)
   );

   // Power state and read handshake
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         power_state <= full_power_state;
         boot <= 1'b1;
         read_seen <= 1'b0;
      end else begin
         power_state <= next_power_state;
         boot <= 1'b0;
         // Any read arms writes; waking disarms them again
         if (rd_take) begin
            read_seen <= 1'b1; // RULE_07
         end else if (wake_write) begin
            read_seen <= 1'b0; // RULE_07
         end
      end
   end

   // Software control bits of the power word
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wake_frame_event_enable <= 1'b0;
         energy_detect_event_enable <= 1'b0;
         wake_output_drive_type <= 1'b0;
         wake_output_pulse_select <= 1'b0;
         wake_output_polarity <= 1'b0;
         wake_output_enable <= 1'b0;
      end else if (pm_write) begin
         wake_frame_event_enable <= bus_wdata[`FPMR_PM_WAKE_FRAME_EN];
         energy_detect_event_enable <= bus_wdata[`FPMR_PM_ENERGY_EN];
         wake_output_drive_type <= bus_wdata[`FPMR_PM_DRIVE_TYPE];
         wake_output_pulse_select <= bus_wdata[`FPMR_PM_PULSE_SEL];
         wake_output_polarity <= bus_wdata[`FPMR_PM_POLARITY];
         wake_output_enable <= bus_wdata[`FPMR_PM_OUT_EN];
      end
   end

   // Wake events: set wins over the clear by dropping both enables
   logic wake_hit;
   logic any_event_enable;
   logic wake_active;
   logic pulse_start;
   assign wake_hit = (wake_frame_event & wake_frame_event_enable) |
                     (energy_detect_event & energy_detect_event_enable); // RULE_14 RULE_15
   assign any_event_enable = wake_frame_event_enable |
                             energy_detect_event_enable;
   assign pulse_start = wake_hit & wake_output_pulse_select; // RULE_18

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wake_event_interrupt <= 1'b0;
      end else begin
         wake_event_interrupt <= wake_hit |
            (wake_event_interrupt & any_event_enable); // RULE_14 RULE_15
      end
   end

   // Pulse mode runs a fixed timer; level mode follows the sticky event
   fpmr_timer u_pulse_timer (
      .clk(clk),
      .reset(reset),
      .start(pulse_start),
      .load(WAKE_PULSE_CYCLES),
      .busy(pulse_busy)
   ); // RULE_18

   assign wake_active = wake_output_pulse_select ? pulse_busy :
                        wake_event_interrupt; // RULE_18

   fpmr_wake_pin u_wake_pin (
      .clk(clk),
      .reset(reset),
      .active(wake_active),
      .out_enable(wake_output_enable),
      .drive_type(wake_output_drive_type),
      .polarity(wake_output_polarity),
      .pin_out(wake_event_output),
      .pin_oe(wake_event_output_oe)
   ); // RULE_14 RULE_15 RULE_16 RULE_17

   // Level snapshots, one cycle behind the datapath
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_status_q <= `FPMR_RST_STATUS_DWORDS; // RULE_01
         rx_used_q <= `FPMR_RST_RX_USED_BYTES; // RULE_02
         tx_status_q <= `FPMR_RST_STATUS_DWORDS; // RULE_03
         tx_free_q <= `FPMR_RST_TX_FREE_BYTES; // RULE_04
      end else begin
         rx_status_q <= rx_status_used_dwords;
         rx_used_q <= rx_data_used_bytes;
         tx_status_q <= tx_status_used_dwords;
         tx_free_q <= tx_data_free_bytes;
      end
   end

   // Read words; reserved positions tied to zero
   assign pm_word = {18'h0_0000, power_state, 1'b0, transceiver_reset,
                     wake_frame_event_enable, energy_detect_event_enable,
                     1'b0, wake_output_drive_type, 2'b00,
                     wake_output_pulse_select, wake_output_polarity,
                     wake_output_enable, device_ready}; // RULE_20 RULE_19
   assign rd_word = hit_rx ? {8'h00, rx_status_q, rx_used_q} : // RULE_01 RULE_02
                    hit_tx ? {8'h00, tx_status_q, tx_free_q} : // RULE_03 RULE_04
                    hit_pm ? pm_word : // RULE_06
                    `FPMR_RST_WORD;

   // Read data registered; power word never blocked by sleep
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bus_rdata <= `FPMR_RST_WORD;
         bus_rdata_valid <= 1'b0;
      end else begin
         bus_rdata_valid <= rd_take;
         if (rd_take) begin
            bus_rdata <= rd_word; // RULE_06
         end
      end
   end

   // Helper counters for the timed outputs
   logic [`FPMR_TIMER_W-1:0] xcvr_run;
   logic [`FPMR_TIMER_W-1:0] pulse_run;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         xcvr_run <= '0;
         pulse_run <= '0;
      end else begin
         xcvr_run <= transceiver_reset ? xcvr_run + 1'b1 : '0;
         pulse_run <= pulse_busy ? pulse_run + 1'b1 : '0;
      end
   end

   sequence pm_read_s;
      rd_take && hit_pm;
   endsequence
   sequence sleep_write_s;
      asleep && wr_take && hit_bt;
   endsequence

   rx_word_read_a: assert property (@(posedge clk) disable iff (reset)
      (rd_take && hit_rx) |=> (bus_rdata_valid && bus_rdata ==
         {8'h00, $past(rx_status_q), $past(rx_used_q)})) // RULE_01
      else $error("receive level word wrong");
   tx_word_read_a: assert property (@(posedge clk) disable iff (reset)
      (rd_take && hit_tx) |=> (bus_rdata[31:24] == 8'h00 &&
         bus_rdata[15:0] == $past(tx_free_q))) // RULE_04
      else $error("transmit level word wrong");
   sleep_read_a: assert property (@(posedge clk) disable iff (reset)
      (pm_read_s ##0 asleep) |=> (bus_rdata_valid &&
         bus_rdata[13:12] == $past(power_state))) // RULE_06
      else $error("power word unreadable asleep");
   write_gate_a: assert property (@(posedge clk) disable iff (reset)
      (wr_take && hit_pm && !read_seen) |=>
         ($stable(wake_output_enable) && $stable(power_state))) // RULE_07
      else $error("write honoured before read");
   reserved_state_a: assert property (@(posedge clk) disable iff (reset)
      (pm_write && req_state == reserved_power_state) |=>
         power_state == full_power_state) // RULE_08
      else $error("reserved state taken");
   byte_test_wake_a: assert property (@(posedge clk) disable iff (reset)
      sleep_write_s |=> (power_state == full_power_state && !read_seen)
         ##1 !device_ready) // RULE_10
      else $error("byte test write did not wake");
   xcvr_hold_a: assert property (@(posedge clk) disable iff (reset)
      $fell(transceiver_reset) |-> $past(xcvr_run) ==
         XCVR_RESET_CYCLES - 1'b1) // RULE_12
      else $error("transceiver reset length wrong");
   xcvr_bit_read_a: assert property (@(posedge clk) disable iff (reset)
      pm_read_s |=> bus_rdata[10] == $past(transceiver_reset)) // RULE_13
      else $error("reset bit does not track");
   wake_int_a: assert property (@(posedge clk) disable iff (reset)
      (energy_detect_event && energy_detect_event_enable) |=>
         wake_event_interrupt) // RULE_15
      else $error("wake interrupt missed");
   pulse_len_a: assert property (@(posedge clk) disable iff (reset)
      $fell(pulse_busy) |-> $past(pulse_run) ==
         WAKE_PULSE_CYCLES - 1'b1) // RULE_18
      else $error("wake pulse length wrong");
   ready_low_a: assert property (@(posedge clk) disable iff (reset)
      asleep |-> !device_ready) // RULE_19
      else $error("ready while asleep");

endmodule
`default_nettype wire

// ==== testbench/fpmr_host.sv ====
`timescale 1ns/1ns
`default_nettype none
// Host processor model on the register bus
module fpmr_host (
   // Clock
   input wire logic clk,
   // Bus toward the register block
   output logic bus_select,
   output logic bus_read,
   output logic bus_write,
   output logic [7:0] bus_addr,
   output logic [31:0] bus_wdata,
   input wire logic [31:0] bus_rdata,
   input wire logic bus_rdata_valid
);
   // Released bus shows inverted values so stale data never passes
   task automatic idle();
      bus_select = 1'b0;
      bus_read = 1'b0;
      bus_write = 1'b0;
      bus_addr = ~bus_addr;
      bus_wdata = ~bus_wdata;
   endtask

   // Start idle at time zero
   initial begin
      bus_addr = 8'h00;
      bus_wdata = 32'h0000_0000;
      idle();
   end

   // Read; after reset or wake, callers write once before the first read to probe the gate
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      #1;
      bus_select = 1'b1;
      bus_read = 1'b1;
      bus_addr = a;
      @(posedge clk);
      #1;
      idle();
      d = bus_rdata_valid ? bus_rdata : 32'hdead_beef;
   endtask

   // Write; only byte test while unready, state 11 only as a probe
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      #1;
      bus_select = 1'b1;
      bus_write = 1'b1;
      bus_addr = a;
      bus_wdata = v;
      @(posedge clk);
      #1;
      idle();
   endtask
   // No transmit data path here, so free space is never overrun
endmodule
`default_nettype wire

// ==== testbench/tb_fpmr_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_fpmr_regs;
   import fpmr_pkg::*;
   localparam int XCVR = 20;
   localparam int PULSE = 30;
   typedef struct packed {
      logic [7:0] rs; logic [15:0] rd; logic [7:0] ts; logic [15:0] tf;
      logic [7:0] a; logic [31:0] exp;
   } fpmr_lvl_row_t;
   typedef struct packed {
      logic [31:0] w; logic wf; logic ed; logic [2:0] early; logic [2:0] late;
   } fpmr_ev_row_t;
   // Level rows: inputs, address, expected word
   fpmr_lvl_row_t lvl [5] = '{
      '{8'hff, 16'hffff, 8'h00, 16'h0000, 8'h7c, 32'h00ff_ffff},
      '{8'h00, 16'h0000, 8'hff, 16'hffff, 8'h80, 32'h00ff_ffff},
      '{8'h12, 16'h0344, 8'h56, 16'h0788, 8'h7c, 32'h0012_0344},
      '{8'h12, 16'h0344, 8'h56, 16'h0788, 8'h80, 32'h0056_0788},
      '{8'hff, 16'hffff, 8'hff, 16'hffff, 8'h88, 32'h0000_0000}};
   // Event rows: power word, events, {interrupt, pin, enable} early/late
   fpmr_ev_row_t evr [7] = '{
      '{32'h0000_0100, 1'b0, 1'b1, 3'b100, 3'b100},
      '{32'h0000_0202, 1'b1, 1'b0, 3'b101, 3'b101},
      '{32'h0000_0246, 1'b1, 1'b0, 3'b111, 3'b111},
      '{32'h0000_014e, 1'b0, 1'b1, 3'b111, 3'b101},
      '{32'h0000_0142, 1'b0, 1'b1, 3'b101, 3'b101},
      '{32'h0000_0002, 1'b1, 1'b1, 3'b000, 3'b000},
      '{32'h0000_020a, 1'b0, 1'b1, 3'b000, 3'b000}};
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic sel, rdq, wrq, valid, xr, ready, irq, pin, pin_oe;
   logic wf_ev = 1'b0;
   logic ed_ev = 1'b0;
   logic [7:0] addr;
   logic [7:0] rx_s = 8'h00;
   logic [7:0] tx_s = 8'h00;
   logic [15:0] rx_d = 16'h0000;
   logic [15:0] tx_f = 16'h1200;
   logic [31:0] wdata, rdata, d;
   fpmr_power_t pstate;
   // Interrupt, pin value and pin enable seen together
   logic [2:0] ev_out;
   assign ev_out = {irq, pin, pin_oe};
   int err_count = 0;
   int n_checks = 0;
   int xr_cnt = 0;
   int xr0 = 0;

   always #5 clk = ~clk;
   // Counts edges with the transceiver held in reset
   always @(posedge clk) if (xr === 1'b1) xr_cnt <= xr_cnt + 1;

   fpmr_regs #(.XCVR_RESET_CYCLES(24'(XCVR)), .WAKE_PULSE_CYCLES(24'(PULSE)))
   u_fpmr_regs (.clk(clk), .reset(reset), .bus_select(sel), .bus_read(rdq),
      .bus_write(wrq), .bus_addr(addr), .bus_wdata(wdata), .bus_rdata(rdata),
      .bus_rdata_valid(valid), .rx_status_used_dwords(rx_s),
      .rx_data_used_bytes(rx_d), .tx_status_used_dwords(tx_s),
      .tx_data_free_bytes(tx_f), .wake_frame_event(wf_ev),
      .energy_detect_event(ed_ev), .power_state(pstate),
      .transceiver_reset(xr), .device_ready(ready),
      .wake_event_interrupt(irq), .wake_event_output(pin),
      .wake_event_output_oe(pin_oe));
   fpmr_host u_fpmr_host (.clk(clk), .bus_select(sel), .bus_read(rdq),
      .bus_write(wrq), .bus_addr(addr), .bus_wdata(wdata), .bus_rdata(rdata),
      .bus_rdata_valid(valid));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Bounded wait for the ready flag
   task automatic wait_ready();
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      chk(32'(ready), 32'h0000_0001);
   endtask
   // Reset for five cycles, outputs checked while held
   task automatic pulse_reset();
      reset = 1'b1;
      cyc(5);
      chk({pstate, xr, ready, irq, pin, pin_oe, valid}, '0);
      reset = 1'b0;
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Watchdog well beyond the expected run of under a thousand cycles
   initial begin
      #100000;
      err_count++;
      $display("watchdog expired");
      tally_and_finish();
   end

   initial begin
      pulse_reset();
      wait_ready();
      u_fpmr_host.wr(8'h84, 32'h0000_0202);
      u_fpmr_host.rd(8'h80, d);
      chk(d, 32'h0000_1200);
      u_fpmr_host.rd(8'h84, d);
      chk(d, 32'h0000_0001);
      $display("test reset done");
      foreach (lvl[i]) begin
         {rx_s, rx_d} = {lvl[i].rs, lvl[i].rd};
         {tx_s, tx_f} = {lvl[i].ts, lvl[i].tf};
         cyc(2);
         u_fpmr_host.rd(lvl[i].a, d);
         chk(d, lvl[i].exp);
      end
      $display("test levels done");
      // Reserved bits set in the write must read back clear
      u_fpmr_host.wr(8'h84, 32'hffff_c3fe);
      u_fpmr_host.rd(8'h84, d);
      chk(d, 32'h0000_034f);
      chk({pin, pin_oe}, 32'h0000_0001);
      foreach (evr[i]) begin
         u_fpmr_host.wr(8'h84, 32'h0000_0000);
         cyc(45);
         u_fpmr_host.wr(8'h84, evr[i].w);
         {wf_ev, ed_ev} = {evr[i].wf, evr[i].ed};
         cyc(1);
         {wf_ev, ed_ev} = 2'b00;
         cyc(2);
         chk(ev_out, evr[i].early);
         cyc(40);
         chk(ev_out, evr[i].late);
      end
      $display("test events done");
      xr0 = xr_cnt;
      u_fpmr_host.wr(8'h84, 32'h0000_0400);
      u_fpmr_host.wr(8'h84, 32'h0000_0400);
      u_fpmr_host.rd(8'h84, d);
      chk(d[10], 32'h0000_0001);
      cyc(30);
      chk(32'(xr_cnt - xr0), 32'(XCVR));
      u_fpmr_host.rd(8'h84, d);
      chk(d, 32'h0000_0001);
      $display("test transceiver reset done");
      for (int s = 1; s < 3; s++) begin
         u_fpmr_host.wr(8'h84, 32'(s) << 12);
         chk(pstate, 32'(s));
         u_fpmr_host.rd(8'h84, d);
         chk(d[13:12], 32'(s));
         u_fpmr_host.wr(8'h64, 32'h0000_0000);
         chk({pstate, ready}, 32'h0000_0000);
         wait_ready();
         u_fpmr_host.wr(8'h84, 32'h0000_0100);
         u_fpmr_host.rd(8'h84, d);
         chk(d, 32'h0000_0001);
      end
      u_fpmr_host.wr(8'h84, 32'h0000_3000);
      chk(pstate, 32'h0000_0000);
      $display("test power states done");
      // Second reset with the interrupt raised
      u_fpmr_host.wr(8'h84, 32'h0000_0100);
      ed_ev = 1'b1;
      cyc(1);
      ed_ev = 1'b0;
      cyc(1);
      chk(irq, 32'h0000_0001);
      pulse_reset();
      wait_ready();
      $display("test second reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
